// ### hdl/ivf_defs.svh
`ifndef IVF_DEFS_SVH
`define IVF_DEFS_SVH
// wishbone byte offsets
`define IVF_A_BASE 6'h00
`define IVF_A_FVEC 6'h04
`define IVF_A_SVF 6'h08
`define IVF_A_SVP 6'h0c
`define IVF_A_WAKE 6'h10
`define IVF_A_LVL 6'h14
`define IVF_A_PLO 6'h18
`define IVF_A_PHI 6'h1c
`define IVF_A_STAT 6'h20
// wake priority register fields
`define IVF_WAKE_HS 3
`define IVF_WAKE_BANK 4
`define IVF_WAKE_AM 5
`define IVF_WAKE_RST 8'h00
// fixed and emulator vector addresses
`define IVF_FIX_UND 24'hffffdc
`define IVF_FIX_OVF 24'hffffe0
`define IVF_FIX_BRK 24'hffffe4
`define IVF_FIX_AM 24'hffffe8
`define IVF_FIX_WDT 24'hfffff0
`define IVF_FIX_NMI 24'hfffff8
`define IVF_FIX_RST 24'hfffffc
`define IVF_EMU_VEC 24'h000020
`define IVF_BRK_RELOC 8'hff
// flag register fields
`define IVF_FLG_I 6
`define IVF_FLG_IPL 12
// timing in cycles and fast path level
`define IVF_FENTRY_CYC 3'h5
`define IVF_FRET_CYC 3'h3
`define IVF_HS_LVL 3'h7
// software interrupt numbers of fixed peripherals
`define IVF_SWN_AD1 6'h07
`define IVF_SWN_DMA0 6'h08
`define IVF_SWN_TA0 6'h0c
`define IVF_SWN_EXT_PIN_IRQ_5 6'h1a
`define IVF_SWN_IIO9 6'h35
`define IVF_SWN_IIO10 6'h36
// special pending slots, lowest index wins
`define IVF_SP_DBG 0
`define IVF_SP_SSTEP 1
`define IVF_SP_UND 2
`define IVF_SP_OVF 3
`define IVF_SP_BRK 4
`define IVF_SP_NMI 5
`define IVF_SP_WDT 6
`define IVF_SP_AM 7
`define IVF_SP_SWI 8
`define IVF_SP_N 9
`endif

// ### hdl/ivf_pkg.sv
package ivf_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FIN = 2'b01,
    ST_FRET = 2'b10,
    ST_RST = 2'b11
  } ivf_state_type;
  typedef struct packed {
    logic [15:0] flags;
    logic [23:0] pc;
  } ivf_core_type;
  typedef struct packed {
    logic valid;
    logic [23:0] addr;
  } ivf_vec_type;
  typedef struct packed {
    logic valid;
    logic flag_ld;
    logic bank1;
    logic [15:0] flags;
    logic [23:0] pc;
  } ivf_jump_type;
endpackage : ivf_pkg

// ### hdl/ivf_vector_unit.sv
`timescale 1ns/10ps
`include "ivf_defs.svh"
// What this block does
// (RULE1) fast entry completes in five cycles, fast return in three
// (RULE2) fast entry saves flags and pc, then jumps to fast vector
// (RULE3) a dedicated fast-return input ends the fast routine
// (RULE4) fast return restores flags and pc from the save registers
// (RULE5) with enable bit 3 set, the level 7 source is fast
// (RULE6) software gives level 7 to one source only
// (RULE7) software avoids second-gen dma with fast path
// (RULE8) software keeps at most two dma channels active with fast path
// (RULE9) fast routine may switch to register bank 1
// (RULE10) normal accepted source branches through its four-byte vector
// (RULE11) fixed table sits at top of memory from ffffdc
// (RULE12) undefined trap at ffffdc, overflow trap at ffffe0
// (RULE13) break uses ffffe4 unless byte ffffe7 is ff, then relocatable
// (RULE14) address match vectors at ffffe8, only while enabled
// (RULE15) watchdog and oscillator stop share fffff0
// (RULE16) nmi pin at fffff8, reset at fffffc
// (RULE17) debug break and single step use 000020, ignore i flag
// (RULE18) application software never touches the emulator vector
// (RULE19) relocatable vector is base plus four times number
// (RULE20) dma 0 to 3 completion map to numbers 8 to 11
// (RULE21) timer a 0 to 4 map to numbers 12 to 16
// (RULE22) pins 5 down to 0 map to numbers 26 to 31
// (RULE23) vectors 53 and 54 shared by intelligent io and can
// (RULE24) break is number 0, a-d channel 1 is number 7
// (RULE25) pending bit clears when its request is accepted
// (RULE26) maskable accepted only when level exceeds processor level
module ivf_vector_unit
  import ivf_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire ivf_core_type core_i,
  input wire logic inst_done_i,
  input wire logic fast_return_instr_i,
  input wire logic undefined_trap_instr_i,
  input wire logic overflow_trap_instr_i,
  input wire logic break_instr_i,
  input wire logic [7:0] brk_top_byte_i,
  input wire logic debugger_break_instr_i,
  input wire logic sstep_i,
  input wire logic int_instr_i,
  input wire logic [5:0] int_num_i,
  input wire logic addr_match_i,
  input wire logic wdt_i,
  input wire logic osc_stop_i,
  input wire logic nmi_pin_n,
  input wire logic [63:0] periph_irq_i,
  input wire logic ad1_irq_i,
  input wire logic [3:0] dma_done_i,
  input wire logic [4:0] ta_irq_i,
  input wire logic [5:0] ext_pin_irq_i,
  input wire logic [1:0] iio_irq_i,
  input wire logic [1:0] can_irq_i,
  output ivf_vec_type vec_o,
  output ivf_jump_type jump_o
);
  ////////////////////////////////////////////////////////////////
  ivf_state_type st_q;
  logic [2:0] cnt_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic [23:0] table_base_reg_q;
  logic [23:0] fast_vector_reg_q;
  logic [15:0] saved_flags_reg_q;
  logic [23:0] saved_counter_reg_q;
  logic [7:0] wake_q;
  logic [5:0] lvl_sel_q;
  logic [2:0] lvl_q [0:63];
  logic [63:0] pend_q;
  logic [`IVF_SP_N-1:0] sp_q;
  logic [5:0] swi_num_q;
  logic [2:0] nmi_s_q;
  ivf_vec_type vec_q;
  ivf_jump_type jump_q;
  logic bank_q;
  logic wr, sp_any, take, mask_ok, acc_hs, acc_norm, acc_sp, fret_take, hs_en;
  logic [63:0] req_v, acc_clr;
  logic [`IVF_SP_N-1:0] sp_set, sp_clr;
  logic [2:0] best_lvl, processor_priority_level;
  logic [5:0] best_idx;
  logic [3:0] sp_idx;
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge
  function automatic logic [23:0] reloc(input logic [23:0] base,
                                        input logic [5:0] num);
    return base + {16'h0000, num, 2'b00}; // RULE19
  endfunction : reloc
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign vec_o = vec_q;
  assign jump_o = jump_q;
  assign hs_en = wake_q[`IVF_WAKE_HS];
  assign processor_priority_level = core_i.flags[`IVF_FLG_IPL +: 3];

  ////////////////////////////////////////////////////////////////
  // wishbone slave, one wait state, write at acking edge
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
      dat_q <= 32'h0;
      if (wb_cyc_i && wb_stb_i && !ack_q && !wb_we_i) begin
        unique case (wb_adr_i)
          `IVF_A_BASE: dat_q <= {8'h00, table_base_reg_q};
          `IVF_A_FVEC: dat_q <= {8'h00, fast_vector_reg_q};
          `IVF_A_SVF: dat_q <= {16'h0000, saved_flags_reg_q};
          `IVF_A_SVP: dat_q <= {8'h00, saved_counter_reg_q};
          `IVF_A_WAKE: dat_q <= {24'h0, wake_q};
          `IVF_A_LVL: dat_q <= {18'h0, lvl_sel_q, 5'h00, lvl_q[lvl_sel_q]};
          `IVF_A_PLO: dat_q <= pend_q[31:0];
          `IVF_A_PHI: dat_q <= pend_q[63:32];
          `IVF_A_STAT: dat_q <= {22'h0, bank_q, cnt_q, sp_any, 3'h0, st_q};
          default: dat_q <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      table_base_reg_q <= 24'h0;
      fast_vector_reg_q <= 24'h0;
      wake_q <= `IVF_WAKE_RST;
      lvl_sel_q <= 6'h00;
      for (int i = 0; i < 64; i++) begin
        lvl_q[i] <= 3'h0;
      end
    end else if (wr) begin
      if (wb_adr_i == `IVF_A_BASE) begin
        table_base_reg_q <= 24'(merge({8'h00, table_base_reg_q}, wb_dat_i, wb_sel_i));
      end
      if (wb_adr_i == `IVF_A_FVEC) begin
        fast_vector_reg_q <= 24'(merge({8'h00, fast_vector_reg_q}, wb_dat_i, wb_sel_i));
      end
      if (wb_adr_i == `IVF_A_WAKE && wb_sel_i[0]) begin
        wake_q <= wb_dat_i[7:0];
      end
      if (wb_adr_i == `IVF_A_LVL && wb_sel_i[1]) begin
        lvl_sel_q <= wb_dat_i[13:8];
        if (wb_sel_i[0]) begin
          lvl_q[wb_dat_i[13:8]] <= wb_dat_i[2:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // source mapping onto software interrupt numbers
  always_comb begin
    req_v = periph_irq_i;
    req_v[`IVF_SWN_AD1] = req_v[`IVF_SWN_AD1] | ad1_irq_i; // RULE24
    for (int i = 0; i < 4; i++) begin
      req_v[`IVF_SWN_DMA0 + i] = req_v[`IVF_SWN_DMA0 + i] | dma_done_i[i]; // RULE20
    end
    for (int i = 0; i < 5; i++) begin
      req_v[`IVF_SWN_TA0 + i] = req_v[`IVF_SWN_TA0 + i] | ta_irq_i[i]; // RULE21
    end
    for (int i = 0; i < 6; i++) begin
      req_v[`IVF_SWN_EXT_PIN_IRQ_5 + i] = req_v[`IVF_SWN_EXT_PIN_IRQ_5 + i] | ext_pin_irq_i[5-i]; // RULE22
    end
    req_v[`IVF_SWN_IIO9] = req_v[`IVF_SWN_IIO9] | iio_irq_i[0] | can_irq_i[0]; // RULE23
    req_v[`IVF_SWN_IIO10] = req_v[`IVF_SWN_IIO10] | iio_irq_i[1] | can_irq_i[1]; // RULE23
  end
  // highest level wins, lowest number on a tie
  always_comb begin
    best_lvl = 3'h0;
    best_idx = 6'h00;
    for (int i = 63; i >= 0; i--) begin
      if (pend_q[i] && lvl_q[i] != 3'h0 && lvl_q[i] >= best_lvl) begin
        best_lvl = lvl_q[i];
        best_idx = 6'(i);
      end
    end
  end

  always_comb begin
    sp_any = |sp_q;
    sp_idx = 4'h0;
    for (int i = `IVF_SP_N - 1; i >= 0; i--) begin
      if (sp_q[i]) begin
        sp_idx = 4'(i);
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // acceptance at instruction boundary
  assign take = st_q == ST_IDLE && inst_done_i && !fast_return_instr_i;
  assign fret_take = st_q == ST_IDLE && fast_return_instr_i; // RULE3
  assign mask_ok = core_i.flags[`IVF_FLG_I] && best_lvl > processor_priority_level; // RULE26
  assign acc_sp = take && sp_any; // RULE17
  assign acc_hs = take && !sp_any && mask_ok && hs_en
                  && best_lvl == `IVF_HS_LVL; // RULE5 RULE6
  assign acc_norm = take && !sp_any && mask_ok && !acc_hs;

  always_comb begin
    acc_clr = 64'h0;
    if (acc_hs || acc_norm) begin
      acc_clr[best_idx] = 1'b1; // RULE25
    end
    sp_clr = '0;
    if (acc_sp) begin
      sp_clr[sp_idx] = 1'b1;
    end
    sp_set = '0;
    sp_set[`IVF_SP_DBG] = debugger_break_instr_i;
    sp_set[`IVF_SP_SSTEP] = sstep_i;
    sp_set[`IVF_SP_UND] = undefined_trap_instr_i;
    sp_set[`IVF_SP_OVF] = overflow_trap_instr_i;
    sp_set[`IVF_SP_BRK] = break_instr_i;
    sp_set[`IVF_SP_NMI] = !nmi_s_q[1] && nmi_s_q[2];
    sp_set[`IVF_SP_WDT] = wdt_i || osc_stop_i; // RULE15
    sp_set[`IVF_SP_AM] = addr_match_i && wake_q[`IVF_WAKE_AM]; // RULE14
    sp_set[`IVF_SP_SWI] = int_instr_i;
  end
  // nmi pin synchroniser and falling edge
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      nmi_s_q <= 3'h7;
    end else begin
      nmi_s_q <= {nmi_s_q[1:0], nmi_pin_n};
    end
  end
  // set wins over clear
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pend_q <= 64'h0;
    end else begin
      pend_q <= (pend_q & ~acc_clr & ~(wr && wb_adr_i == `IVF_A_PLO
                ? {32'h0, wb_dat_i} : 64'h0)
                & ~(wr && wb_adr_i == `IVF_A_PHI ? {wb_dat_i, 32'h0} : 64'h0))
                | req_v;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sp_q <= '0;
      swi_num_q <= 6'h00;
    end else begin
      sp_q <= (sp_q & ~sp_clr) | sp_set;
      if (int_instr_i) begin
        swi_num_q <= int_num_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // vector address selection for special sources
  function automatic logic [23:0] sp_vec(input logic [3:0] idx,
                                         input logic [23:0] base,
                                         input logic [7:0] top,
                                         input logic [5:0] num);
    unique case (idx)
      4'(`IVF_SP_DBG), 4'(`IVF_SP_SSTEP): sp_vec = `IVF_EMU_VEC; // RULE17
      4'(`IVF_SP_UND): sp_vec = `IVF_FIX_UND; // RULE11 RULE12
      4'(`IVF_SP_OVF): sp_vec = `IVF_FIX_OVF; // RULE12
      4'(`IVF_SP_BRK): sp_vec = top == `IVF_BRK_RELOC
                                ? reloc(base, 6'h00) : `IVF_FIX_BRK; // RULE13 RULE24
      4'(`IVF_SP_NMI): sp_vec = `IVF_FIX_NMI; // RULE16
      4'(`IVF_SP_WDT): sp_vec = `IVF_FIX_WDT; // RULE15
      4'(`IVF_SP_AM): sp_vec = `IVF_FIX_AM; // RULE14
      default: sp_vec = reloc(base, num);
    endcase
  endfunction : sp_vec

  ////////////////////////////////////////////////////////////////
  // sequencer: reset vector, normal vector, fast entry and return
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= ST_RST;
      cnt_q <= 3'h0;
      vec_q <= '0;
      jump_q <= '0;
      bank_q <= 1'b0;
      saved_flags_reg_q <= 16'h0;
      saved_counter_reg_q <= 24'h0;
    end else begin
      vec_q.valid <= 1'b0;
      jump_q.valid <= 1'b0;
      unique case (st_q)
        ST_RST: begin
          vec_q <= '{valid: 1'b1, addr: `IVF_FIX_RST}; // RULE16
          st_q <= ST_IDLE;
        end
        ST_IDLE: begin
          if (fret_take) begin
            st_q <= ST_FRET;
            cnt_q <= 3'h1;
          end else if (acc_sp) begin
            vec_q <= '{valid: 1'b1,
                       addr: sp_vec(sp_idx, table_base_reg_q, brk_top_byte_i, swi_num_q)};
          end else if (acc_hs) begin
            saved_flags_reg_q <= core_i.flags; // RULE2
            saved_counter_reg_q <= core_i.pc; // RULE2
            st_q <= ST_FIN;
            cnt_q <= 3'h1;
          end else if (acc_norm) begin
            vec_q <= '{valid: 1'b1, addr: reloc(table_base_reg_q, best_idx)}; // RULE10
          end
        end
        ST_FIN: begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == `IVF_FENTRY_CYC - 3'h1) begin // RULE1
            jump_q.valid <= 1'b1;
            jump_q.flag_ld <= 1'b0;
            jump_q.pc <= fast_vector_reg_q; // RULE2
            jump_q.flags <= core_i.flags;
            jump_q.bank1 <= wake_q[`IVF_WAKE_BANK]; // RULE9
            bank_q <= wake_q[`IVF_WAKE_BANK]; // RULE9
            st_q <= ST_IDLE;
            cnt_q <= 3'h0;
          end
        end
        ST_FRET: begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == `IVF_FRET_CYC - 3'h1) begin // RULE1
            jump_q.valid <= 1'b1;
            jump_q.flag_ld <= 1'b1;
            jump_q.pc <= saved_counter_reg_q; // RULE4
            jump_q.flags <= saved_flags_reg_q; // RULE4
            jump_q.bank1 <= 1'b0; // RULE9
            bank_q <= 1'b0;
            st_q <= ST_IDLE;
            cnt_q <= 3'h0;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  a_fast_entry_time: assert property (acc_hs |-> ##5 (jump_q.valid && !jump_q.flag_ld)) // RULE1
    else $error("fast entry not done in five cycles");
  a_fast_ret_time: assert property (fret_take |-> ##3 (jump_q.valid && jump_q.flag_ld)) // RULE1
    else $error("fast return not done in three cycles");
  a_save_regs: assert property (acc_hs |=> saved_flags_reg_q == $past(core_i.flags) // RULE2
    && saved_counter_reg_q == $past(core_i.pc))
    else $error("flags or pc not saved");
  a_fast_vec_pc: assert property (jump_q.valid && !jump_q.flag_ld // RULE2
    |-> jump_q.pc == $past(fast_vector_reg_q))
    else $error("fast entry pc wrong");
  a_restore_regs: assert property (fret_take |-> ##3 // RULE4
    jump_q.flags == $past(saved_flags_reg_q, 3) && jump_q.pc == $past(saved_counter_reg_q, 3))
    else $error("fast return restore wrong");
  a_hs_select: assert property (st_q == ST_IDLE ##1 st_q == ST_FIN // RULE5
    |-> $past(hs_en) && $past(lvl_q[best_idx]) == `IVF_HS_LVL)
    else $error("fast path taken without level 7");
  a_mask_level: assert property (take && !sp_any // RULE26
    && !(core_i.flags[`IVF_FLG_I] && lvl_q[best_idx] > processor_priority_level)
    |=> !vec_q.valid && st_q == ST_IDLE)
    else $error("maskable taken at low level");
  a_reloc_addr: assert property (acc_norm |=> vec_q.valid // RULE10
    && vec_q.addr == $past(table_base_reg_q) + {16'h0000, $past(best_idx), 2'b00})
    else $error("relocatable vector address wrong");
  a_pend_clear: assert property (acc_norm |=> !pend_q[$past(best_idx)] // RULE25
    || $past(req_v[best_idx]))
    else $error("pending bit not cleared");
  a_am_gate: assert property ($rose(sp_q[`IVF_SP_AM]) |-> $past(wake_q[`IVF_WAKE_AM])) // RULE14
    else $error("address match raised while disabled");
  a_emu_vec: assert property (acc_sp && sp_idx <= 4'h1 |=> vec_q.addr == 24'h000020) // RULE17
    else $error("emulator vector wrong");
  c_fast_entry: cover property (acc_hs ##5 jump_q.valid);
  c_fast_return: cover property (fret_take ##3 jump_q.valid);
  c_normal_vec: cover property (acc_norm ##1 vec_q.valid);
  c_nmi_vec: cover property (acc_sp && sp_idx == 4'h5);
endmodule : ivf_vector_unit

// ### test/ivf_core_model.sv
`timescale 1ns/10ps
module ivf_core_model
  import ivf_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic step_i,
  input wire logic ld_i,
  input wire ivf_core_type ld_val_i,
  input wire ivf_vec_type vec_i,
  input wire ivf_jump_type jump_i,
  output ivf_core_type core_o,
  output logic inst_done_o
);
  ////////////////////////////////////////////////////////////////////////////
  // instruction boundary, one pulse per step request
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      inst_done_o <= 1'b0;
    end else begin
      inst_done_o <= step_i;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // flags and pc: loaded, vectored or restored
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      core_o <= '0;
    end else if (ld_i) begin
      core_o <= ld_val_i;
    end else if (jump_i.valid) begin
      core_o.pc <= jump_i.pc;
      if (jump_i.flag_ld) begin
        core_o.flags <= jump_i.flags;
      end
    end else if (vec_i.valid) begin
      core_o.pc <= vec_i.addr;
    end
  end
endmodule : ivf_core_model

// ### test/ivf_vector_unit_tb.sv
`timescale 1ns/10ps
`include "ivf_defs.svh"
module ivf_vector_unit_tb
  import ivf_pkg::*;
;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [5:0] wb_adr = 6'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h0, wb_dat_o, q;
  logic wb_ack, inst_done;
  logic [8:0] sp = 9'h000;
  logic [19:0] mk = 20'h00000;
  logic [63:0] pi = 64'h0;
  logic fret = 1'b0, nmi_n = 1'b1, step = 1'b0, ld = 1'b0;
  logic [7:0] top = 8'h00;
  logic [5:0] inum = 6'h00;
  logic [23:0] base = 24'h012300;
  ivf_core_type ldv = '0, core;
  ivf_vec_type vec;
  ivf_jump_type jump, jv;
  logic [23:0] vq[$];
  ivf_jump_type jq[$];
  logic [23:0] fx[8] = '{24'hffffdc, 24'hffffe0, 24'hffffe4, 24'hffffe8,
                         24'hfffff0, 24'hfffff0, 24'h000020, 24'h000020};
  int mb[11] = '{0, 1, 4, 5, 9, 15, 10, 16, 18, 19, 17};
  int mn[11] = '{7, 8, 11, 12, 16, 26, 31, 53, 53, 54, 54};
  int cyc = 0, acc_cyc = 0, ret_cyc = 0, jump_cyc = 0, fail_count = 0, check_count = 0;
  always #2 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////////
  ivf_vector_unit i_dut (.mclk(mclk), .arst_n(arst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack), .core_i(core), .inst_done_i(inst_done),
    .fast_return_instr_i(fret), .undefined_trap_instr_i(sp[0]),
    .overflow_trap_instr_i(sp[1]), .break_instr_i(sp[2]), .brk_top_byte_i(top),
    .debugger_break_instr_i(sp[6]), .sstep_i(sp[7]), .int_instr_i(sp[8]),
    .int_num_i(inum), .addr_match_i(sp[3]), .wdt_i(sp[4]), .osc_stop_i(sp[5]),
    .nmi_pin_n(nmi_n), .periph_irq_i(pi), .ad1_irq_i(mk[0]), .dma_done_i(mk[4:1]),
    .ta_irq_i(mk[9:5]), .ext_pin_irq_i(mk[15:10]), .iio_irq_i(mk[17:16]),
    .can_irq_i(mk[19:18]), .vec_o(vec), .jump_o(jump));
  ivf_core_model i_core (.mclk(mclk), .arst_n(arst_n), .step_i(step), .ld_i(ld),
    .ld_val_i(ldv), .vec_i(vec), .jump_i(jump), .core_o(core), .inst_done_o(inst_done));
  ////////////////////////////////////////////////////////////////////////////
  // monitor: collects vectors, jumps and cycle stamps
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (inst_done === 1'b1) acc_cyc <= cyc;
    if (fret === 1'b1) ret_cyc <= cyc;
    if (vec.valid === 1'b1) vq.push_back(vec.addr);
    if (jump.valid === 1'b1) begin
      jq.push_back(jump);
      jump_cyc <= cyc;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic xfer(input logic we, input logic [5:0] adr, input logic [31:0] d,
                      input logic [3:0] sel);
    int n;
    n = 0;
    @(posedge mclk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat <= d;
    wb_sel <= sel;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    if (n >= 50) check(32'h1, 32'h0);
  endtask : xfer
  task automatic pulse(input logic [8:0] s, input logic [19:0] m, input logic [63:0] p);
    @(posedge mclk);
    sp <= s;
    mk <= m;
    pi <= p;
    @(posedge mclk);
    sp <= '0;
    mk <= '0;
    pi <= '0;
  endtask : pulse
  task automatic ld_core(input logic [15:0] f, input logic [23:0] pc);
    @(posedge mclk);
    ld <= 1'b1;
    ldv <= '{flags: f, pc: pc};
    @(posedge mclk);
    ld <= 1'b0;
  endtask : ld_core
  task automatic expect_vec(input logic do_step, input logic [23:0] exp);
    logic [23:0] got;
    if (do_step) begin
      @(posedge mclk) step <= 1'b1;
      @(posedge mclk) step <= 1'b0;
    end
    repeat (20) if (vq.size() == 0) @(negedge mclk);
    got = (vq.size() != 0) ? vq.pop_front() : 24'hxxxxxx;
    check({8'h00, got}, {8'h00, exp});
  endtask : expect_vec
  task automatic no_vec();
    @(posedge mclk) step <= 1'b1;
    @(posedge mclk) step <= 1'b0;
    repeat (10) @(negedge mclk);
    check(vq.size(), 32'h0);
    vq.delete();
  endtask : no_vec
  task automatic wait_jump();
    repeat (20) if (jq.size() == 0) @(negedge mclk);
    jv = (jq.size() != 0) ? jq.pop_front() : 'x;
  endtask : wait_jump
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    fail_count++;
    print_verdict();
  end
  initial begin
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    expect_vec(1'b0, `IVF_FIX_RST);
    xfer(1'b1, `IVF_A_BASE, {8'h00, base}, 4'hf);
    xfer(1'b0, `IVF_A_BASE, 32'h0, 4'hf);
    check(q, {8'h00, base});
    xfer(1'b0, 6'h24, 32'h0, 4'hf);
    check(q, 32'h0);
    xfer(1'b1, `IVF_A_WAKE, 32'h20, 4'hf);
    for (int i = 0; i < 8; i++) begin
      pulse(9'h001 << i, '0, '0);
      expect_vec(1'b1, fx[i]);
    end
    @(posedge mclk) top <= `IVF_BRK_RELOC;
    pulse(9'h004, '0, '0);
    expect_vec(1'b1, base);
    @(posedge mclk) nmi_n <= 1'b0;
    repeat (4) @(posedge mclk);
    nmi_n <= 1'b1;
    expect_vec(1'b1, `IVF_FIX_NMI);
    @(posedge mclk) inum <= 6'h3f;
    pulse(9'h100, '0, '0);
    expect_vec(1'b1, base + 24'd252);
    xfer(1'b1, `IVF_A_WAKE, 32'h0, 4'hf);
    pulse(9'h008, '0, '0);
    no_vec();
    ld_core(16'h0040, 24'h0);
    for (int i = 0; i < 11; i++) begin
      xfer(1'b1, `IVF_A_LVL, {18'h0, 6'(mn[i]), 5'h0, 3'h1}, 4'h3);
      xfer(1'b0, `IVF_A_LVL, 32'h0, 4'hf);
      check(q, {18'h0, 6'(mn[i]), 5'h0, 3'h1});
      pulse('0, 20'h1 << mb[i], '0);
      expect_vec(1'b1, base + 24'(4 * mn[i]));
      xfer(1'b0, mn[i] < 32 ? `IVF_A_PLO : `IVF_A_PHI, 32'h0, 4'hf);
      check({31'h0, q[mn[i] % 32]}, 32'h0);
    end
    xfer(1'b1, `IVF_A_LVL, {18'h0, 6'd40, 5'h0, 3'h2}, 4'h3);
    pulse('0, '0, 64'h1 << 40);
    expect_vec(1'b1, base + 24'd160);
    xfer(1'b1, `IVF_A_LVL, {18'h0, 6'd21, 5'h0, 3'h3}, 4'h3);
    ld_core(16'h3040, 24'h0);
    pulse('0, '0, 64'h1 << 21);
    no_vec();
    xfer(1'b0, `IVF_A_PLO, 32'h0, 4'hf);
    check({31'h0, q[21]}, 32'h1);
    ld_core(16'h2040, 24'h0);
    expect_vec(1'b1, base + 24'd84);
    pulse('0, '0, 64'h1 << 22);
    xfer(1'b1, `IVF_A_PLO, 32'h0040_0000, 4'hf);
    xfer(1'b0, `IVF_A_PLO, 32'h0, 4'hf);
    check({31'h0, q[22]}, 32'h0);
    // one level 7 source, no dma in use while fast path enabled
    // emulator vector register never read or written by the bench
    xfer(1'b1, `IVF_A_LVL, {18'h0, 6'd12, 5'h0, 3'h7}, 4'h3);
    ld_core(16'h0040, 24'h0);
    pulse('0, 20'h00020, '0);
    expect_vec(1'b1, base + 24'd48);
    xfer(1'b1, `IVF_A_WAKE, 32'h18, 4'hf);
    xfer(1'b1, `IVF_A_FVEC, 32'h00abc0, 4'hf);
    ld_core(16'h0040, 24'h123456);
    vq.delete();
    pulse('0, 20'h00020, '0);
    @(posedge mclk) step <= 1'b1;
    @(posedge mclk) step <= 1'b0;
    wait_jump();
    check({8'h0, jv.pc}, 32'h00abc0);
    check({30'h0, jv.flag_ld, jv.bank1}, 32'h1);
    check(32'(jump_cyc - acc_cyc), 32'h5);
    check(vq.size(), 32'h0);
    xfer(1'b0, `IVF_A_SVF, 32'h0, 4'hf);
    check(q, 32'h0040);
    xfer(1'b0, `IVF_A_SVP, 32'h0, 4'hf);
    check(q, 32'h123456);
    ld_core(16'h7000, 24'h0);
    @(posedge mclk) fret <= 1'b1;
    @(posedge mclk) fret <= 1'b0;
    wait_jump();
    check({8'h0, jv.pc}, 32'h123456);
    check({16'h0, jv.flags}, 32'h0040);
    check({30'h0, jv.flag_ld, jv.bank1}, 32'h2);
    check(32'(jump_cyc - ret_cyc), 32'h3);
    repeat (2) @(negedge mclk);
    check({16'h0, core.flags}, 32'h0040);
    print_verdict();
  end
endmodule : ivf_vector_unit_tb
